//--- logic/bzcs_zero_cross_sampler.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps

module bzcs_zero_cross_sampler (
    input  wire logic                          ref_clk_i,          // 40 MHz core clock
    input  wire logic                          rst_i,              // sync reset, high
    input  wire logic [bzcs_pkg::ADDR_W-1:0]   addr_i,             // register address
    input  wire logic [bzcs_pkg::DATA_W-1:0]   wr_data_i,          // register write data
    input  wire logic                          wr_i,               // write strobe
    input  wire logic                          rd_i,               // read strobe
    output logic      [bzcs_pkg::DATA_W-1:0]   rd_data_o,          // read data, next cycle
    input  wire logic [bzcs_pkg::NUM_PH-1:0]   high_side_drive_in_i, // high-side pwm pins
    input  wire logic [bzcs_pkg::NUM_PH-1:0]   low_side_drive_in_i,  // low-side pwm pins
    input  wire logic                          step_pulse_in_i,    // step pulse pin
    input  wire logic                          cmp_gnd_i,          // ground comparator
    input  wire logic                          cmp_supply_i,       // supply comparator
    input  wire logic                          cmp_half_i,         // half-supply comparator
    output logic      [bzcs_pkg::NUM_PH-1:0]   phase_route_o,      // floating phase, one-hot
    output logic                               zero_cross_out_o    // sampled zero crossing
);
    import bzcs_pkg::*;

    typedef struct packed {
        logic              comparator_select;
        logic              pwm_side_select;
        logic              sample_polarity;
        logic              sample_bypass;
        logic              counter_update_mode;
        logic              step_direction;
        logic [STEP_W-1:0] step_counter_value;
        logic [NUM_PH-1:0] phase_route;
        logic              zero_cross_out;
        logic [DIV_W-1:0]  div_cnt;
        logic [DATA_W-1:0] rd_data;
    } bzcs_state_t;

    bzcs_state_t st;
    bzcs_state_t next_st;

    logic [SYN_W-1:0]  syn_lvl;
    logic [SYN_W-1:0]  syn_rise;
    logic [SYN_W-1:0]  syn_fall;
    logic [NUM_PH-1:0] high_lvl;
    logic [NUM_PH-1:0] low_lvl;
    logic [NUM_PH-1:0] high_rise;
    logic [NUM_PH-1:0] high_fall;
    logic [NUM_PH-1:0] low_rise;
    logic [NUM_PH-1:0] low_fall;
    logic              step_rise;
    logic              tick;
    logic [1:0]        drv_idx;
    logic              use_low;
    logic              edge_rising;
    logic              samp_rise;
    logic              samp_fall;
    logic              edge_evt;
    logic              sample_evt;
    logic              cmp_level;
    logic [STEP_W-1:0] step_up;
    logic [STEP_W-1:0] step_down;
    logic              step_legal;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] rd_mux;

    // every pwm, step and comparator pin passes two flops before use
    bzcs_sync_edge #(
        .WIDTH (SYN_W)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   ({cmp_half_i, cmp_supply_i, cmp_gnd_i, step_pulse_in_i,
                     low_side_drive_in_i, high_side_drive_in_i}),
        .level_o   (syn_lvl),
        .rise_o    (syn_rise),
        .fall_o    (syn_fall)
    );

    // lane split of the synchroniser outputs
    assign high_lvl  = syn_lvl[SYN_HIGH +: NUM_PH];
    assign low_lvl   = syn_lvl[SYN_LOW +: NUM_PH];
    assign high_rise = syn_rise[SYN_HIGH +: NUM_PH];
    assign high_fall = syn_fall[SYN_HIGH +: NUM_PH];
    assign low_rise  = syn_rise[SYN_LOW +: NUM_PH];
    assign low_fall  = syn_fall[SYN_LOW +: NUM_PH];
    assign step_rise = syn_rise[SYN_STEP];

    // internal sample clock as a one-cycle tick every SAMPLE_DIV cycles
    assign tick = (st.div_cnt == DIV_W'(SAMPLE_DIV - 1));

    // driving phase follows the step counter; step one drives phase one
    assign drv_idx = drive_phase_idx(st.step_counter_value);

    // freewheeling turn-off lives on the opposite side of the pwm
    assign use_low = st.pwm_side_select ^
                     (~st.comparator_select & st.sample_polarity);

    // only turn-on with polarity zero on ground/supply; else turn-off
    assign edge_rising = ~st.comparator_select & ~st.sample_polarity;

    // edge pulses of the selected drive input
    assign samp_rise = use_low ? low_rise[drv_idx] : high_rise[drv_idx];
    assign samp_fall = use_low ? low_fall[drv_idx] : high_fall[drv_idx];
    assign edge_evt  = edge_rising ? samp_rise : samp_fall;

    // bypass replaces the pwm edge by the 10 MHz tick
    assign sample_evt = st.sample_bypass ? tick : edge_evt;

    // half-supply when select set; ground or supply by side otherwise
    always_comb begin
        if (st.comparator_select) begin
            cmp_level = syn_lvl[SYN_HALF];
        end else if (st.pwm_side_select) begin
            cmp_level = syn_lvl[SYN_SUP];
        end else begin
            cmp_level = syn_lvl[SYN_GND];
        end
    end

    // wrap in both directions
    assign step_up    = (st.step_counter_value == STEP_MAX) ? STEP_MIN :
                        st.step_counter_value + 3'h1;
    assign step_down  = (st.step_counter_value == STEP_MIN) ? STEP_MAX :
                        st.step_counter_value - 3'h1;
    assign step_legal = (wr_data_i[STEP_W-1:0] >= STEP_MIN) &&
                        (wr_data_i[STEP_W-1:0] <= STEP_MAX);

    // read words; unused bits read as zero
    always_comb begin
        ctrl_word                   = '0;
        ctrl_word[CTRL_CMP_SEL]     = st.comparator_select;
        ctrl_word[CTRL_SIDE]        = st.pwm_side_select;
        ctrl_word[CTRL_POL]         = st.sample_polarity;
        ctrl_word[CTRL_BYPASS]      = st.sample_bypass;
        ctrl_word[CTRL_MODE]        = st.counter_update_mode;
        ctrl_word[CTRL_DIR]         = st.step_direction;
        stat_word                   = '0;
        stat_word[STAT_ZC]          = st.zero_cross_out;
        stat_word[STAT_CMP]         = cmp_level;
        stat_word[STAT_ROUTE +: NUM_PH] = st.phase_route;
        unique case (addr_i)
            ADDR_CTRL:   rd_mux = ctrl_word;
            ADDR_STEP:   rd_mux = {{(DATA_W - STEP_W){1'b0}}, st.step_counter_value};
            ADDR_STATUS: rd_mux = stat_word;
            default:     rd_mux = '0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.div_cnt = tick ? '0 : st.div_cnt + DIV_W'(1);
        if (wr_i && (addr_i == ADDR_CTRL)) begin
            next_st.comparator_select   = wr_data_i[CTRL_CMP_SEL];
            next_st.pwm_side_select     = wr_data_i[CTRL_SIDE];
            next_st.sample_polarity     = wr_data_i[CTRL_POL];
            next_st.sample_bypass       = wr_data_i[CTRL_BYPASS];
            next_st.counter_update_mode = wr_data_i[CTRL_MODE];
            next_st.step_direction      = wr_data_i[CTRL_DIR];
        end
        // serial write only in serial mode, pulses only in pulse mode
        if (!st.counter_update_mode) begin
            if (wr_i && (addr_i == ADDR_STEP) && step_legal) begin
                next_st.step_counter_value = wr_data_i[STEP_W-1:0];
            end
        end else if (step_rise) begin
            next_st.step_counter_value = st.step_direction ? step_down : step_up;
        end
        // route follows the counter without extra lag
        next_st.phase_route = float_phase_oh(next_st.step_counter_value);
        // hold the last sample between sample events
        if (sample_evt) begin
            next_st.zero_cross_out = cmp_level;
        end
        // read data stands in the cycle after the strobe only
        next_st.rd_data = rd_i ? rd_mux : '0;
    end

    // state register, defined after reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            next_st_reset();
        end else begin
            st <= next_st;
        end
    end

    // reset values kept apart so the register process stays short
    task automatic next_st_reset();
        st                     <= '0;
        st.comparator_select   <= CTRL_RESET[CTRL_CMP_SEL];
        st.pwm_side_select     <= CTRL_RESET[CTRL_SIDE];
        st.sample_polarity     <= CTRL_RESET[CTRL_POL];
        st.sample_bypass       <= CTRL_RESET[CTRL_BYPASS];
        st.counter_update_mode <= CTRL_RESET[CTRL_MODE];
        st.step_direction      <= CTRL_RESET[CTRL_DIR];
        st.step_counter_value  <= STEP_RESET;
        st.phase_route         <= float_phase_oh(STEP_RESET);
    endtask

    assign rd_data_o        = st.rd_data;
    assign phase_route_o    = st.phase_route;
    assign zero_cross_out_o = st.zero_cross_out;

    // checks on the design's own signals
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // bypass tick comes every fourth cycle
    sequence tick_gap_s;
        !tick [*3] ##1 tick;
    endsequence

    // a pulse-mode step rise seen with direction up
    sequence step_up_s;
        st.counter_update_mode && !st.step_direction && step_rise;
    endsequence

    // a pulse-mode step rise seen with direction down
    sequence step_down_s;
        st.counter_update_mode && st.step_direction && step_rise;
    endsequence

    route_onehot_a: assert property ($onehot(phase_route_o))
        else $error("floating phase route not one-hot");

    step_range_a: assert property (
        (st.step_counter_value >= STEP_MIN) && (st.step_counter_value <= STEP_MAX))
        else $error("step counter out of its six states");

    zc_sample_a: assert property (
        sample_evt |=> zero_cross_out_o == $past(cmp_level))
        else $error("zero cross output missed the selected comparator");

    zc_hold_a: assert property (!sample_evt |=> $stable(zero_cross_out_o))
        else $error("zero cross output changed without a sample");

    edge_only_a: assert property (
        !st.sample_bypass && sample_evt |-> (
            (!st.comparator_select && !st.sample_polarity)
            ? (high_rise[drv_idx] || low_rise[drv_idx])
            : (high_fall[drv_idx] || low_fall[drv_idx])))
        else $error("sampling edge depends on more than select and polarity");

    step_one_a: assert property (
        st.step_counter_value == STEP_MIN |=> phase_route_o == 3'h4 || $changed(st.step_counter_value))
        else $error("step one does not float phase three");

    half_side_a: assert property (
        st.comparator_select && !st.sample_bypass && drv_idx == 2'h0
        |-> sample_evt == (st.pwm_side_select ? low_fall[0] : high_fall[0]))
        else $error("half-supply sample not on phase one turn-off");

    bypass_rate_a: assert property (
        st.sample_bypass && tick |-> sample_evt ##1 tick_gap_s)
        else $error("bypass sampling not at the internal 10 MHz rate");

    gnd_on_a: assert property (
        !st.comparator_select && !st.pwm_side_select && !st.sample_polarity
        && !st.sample_bypass |-> sample_evt == high_rise[drv_idx]
        && cmp_level == syn_lvl[SYN_GND])
        else $error("ground comparator not on high-side turn-on");

    gnd_off_a: assert property (
        !st.comparator_select && !st.pwm_side_select && st.sample_polarity
        && !st.sample_bypass |-> sample_evt == low_fall[drv_idx])
        else $error("ground comparator not on low-side turn-off");

    supply_edge_a: assert property (
        !st.comparator_select && st.pwm_side_select && !st.sample_bypass
        |-> cmp_level == syn_lvl[SYN_SUP] && sample_evt ==
        (st.sample_polarity ? high_fall[drv_idx] : low_rise[drv_idx]))
        else $error("supply comparator on the wrong edge");

    half_sel_a: assert property (
        st.comparator_select |-> cmp_level == syn_lvl[SYN_HALF])
        else $error("half-supply comparator not selected");

    serial_only_a: assert property (
        !st.counter_update_mode && !(wr_i && addr_i == ADDR_STEP)
        |=> $stable(st.step_counter_value))
        else $error("step counter moved outside a serial write");

    pulse_up_a: assert property (
        step_up_s |=> st.step_counter_value ==
        (($past(st.step_counter_value) == STEP_MAX) ? STEP_MIN : $past(st.step_counter_value) + 3'h1))
        else $error("step pulse did not advance the counter");

    step_wrap_a: assert property (
        st.counter_update_mode && st.step_direction && step_rise
        && st.step_counter_value == STEP_MIN |=> st.step_counter_value == STEP_MAX)
        else $error("step counter did not wrap downward");

    step_pulse_a: assert property (step_rise |=> !step_rise)
        else $error("step edge lasted more than one cycle");

    // sample events come only from the driving phase, or only from the tick in bypass
    drive_pin_a: assert property (
        !st.sample_bypass && sample_evt
        |-> (high_rise[drv_idx] || high_fall[drv_idx] || low_rise[drv_idx] || low_fall[drv_idx]))
        else $error("sample taken from a drive pin of another phase");

    phase_one_a: assert property (
        st.step_counter_value == STEP_MIN && !st.sample_bypass && sample_evt
        |-> (high_rise[0] || high_fall[0] || low_rise[0] || low_fall[0]))
        else $error("step one sample not from a phase one drive pin");

    half_off_a: assert property (
        st.comparator_select && !st.sample_bypass && sample_evt
        |-> (st.pwm_side_select ? low_fall[drv_idx] : high_fall[drv_idx]))
        else $error("half-supply sample not on a driving turn-off edge");

    bypass_only_a: assert property (
        st.sample_bypass && !tick |-> !sample_evt)
        else $error("pwm edge sampled while bypass is set");

    // pulse mode is exclusive: register writes must not move the counter
    pulse_only_a: assert property (
        st.counter_update_mode && !step_rise |=> $stable(st.step_counter_value))
        else $error("step counter moved in pulse mode without a pulse");

    pulse_down_a: assert property (
        step_down_s ##0 (st.step_counter_value != STEP_MIN)
        |=> st.step_counter_value == $past(st.step_counter_value) - 3'h1)
        else $error("step pulse did not move the counter down");

    route_table_a: assert property (
        phase_route_o == (
            (st.step_counter_value == 3'h1 || st.step_counter_value == 3'h4) ? 3'h4 :
            (st.step_counter_value == 3'h2 || st.step_counter_value == 3'h5) ? 3'h2 : 3'h1))
        else $error("floating phase does not follow the step table");

    read_once_a: assert property (!rd_i |=> rd_data_o == '0)
        else $error("read data present without a read strobe");

endmodule // bzcs_zero_cross_sampler

//--- pkg/bzcs_pkg.sv
package bzcs_pkg;

    // clock and internal sample clock
    localparam int CLK_HZ        = 40_000_000;
    localparam int SAMPLE_HZ     = 10_000_000;
    localparam int SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
    localparam int DIV_W         = $clog2(SAMPLE_DIV);

    // register port
    localparam int ADDR_W        = 4;
    localparam int DATA_W        = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STEP   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

    // control register fields
    localparam int CTRL_CMP_SEL  = 0;
    localparam int CTRL_SIDE     = 1;
    localparam int CTRL_POL      = 2;
    localparam int CTRL_BYPASS   = 3;
    localparam int CTRL_MODE     = 4;
    localparam int CTRL_DIR      = 5;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

    // status register fields
    localparam int STAT_ZC       = 0;
    localparam int STAT_CMP      = 1;
    localparam int STAT_ROUTE    = 4;

    // step counter range
    localparam int STEP_W        = 3;
    localparam logic [STEP_W-1:0] STEP_MIN   = 3'h1;
    localparam logic [STEP_W-1:0] STEP_MAX   = 3'h6;
    localparam logic [STEP_W-1:0] STEP_RESET = 3'h1;

    // synchroniser lane layout
    localparam int NUM_PH        = 3;
    localparam int SYN_HIGH      = 0;
    localparam int SYN_LOW       = 3;
    localparam int SYN_STEP      = 6;
    localparam int SYN_GND       = 7;
    localparam int SYN_SUP       = 8;
    localparam int SYN_HALF      = 9;
    localparam int SYN_W         = 10;

    // floating phase per step, one-hot, bit 0 is phase 1
    function automatic logic [NUM_PH-1:0] float_phase_oh(input logic [STEP_W-1:0] step);
        unique case (step)
            3'h1, 3'h4: float_phase_oh = 3'h4;
            3'h2, 3'h5: float_phase_oh = 3'h2;
            3'h3, 3'h6: float_phase_oh = 3'h1;
            default:    float_phase_oh = 3'h0;
        endcase
    endfunction

    // driving phase index per step, 0 is phase 1
    function automatic logic [1:0] drive_phase_idx(input logic [STEP_W-1:0] step);
        unique case (step)
            3'h1, 3'h2: drive_phase_idx = 2'h0;
            3'h3, 3'h4: drive_phase_idx = 2'h1;
            3'h5, 3'h6: drive_phase_idx = 2'h2;
            default:    drive_phase_idx = 2'h0;
        endcase
    endfunction

endpackage

//--- logic/bzcs_sync_edge.sv
`timescale 1ns/1ps

module bzcs_sync_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_i,  // core clock
    input  wire logic             rst_i,      // sync reset, high
    input  wire logic [WIDTH-1:0] async_i,    // pins from outside the domain
    output logic      [WIDTH-1:0] level_o,    // synchronised level
    output logic      [WIDTH-1:0] rise_o,     // one-cycle rising pulse
    output logic      [WIDTH-1:0] fall_o      // one-cycle falling pulse
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } bzcs_sync_t;

    bzcs_sync_t st;
    bzcs_sync_t next_st;

    // s1 only feeds s2; edges look at s2 against s3
    always_comb begin
        next_st    = st;
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.s2;
    assign rise_o  = st.s2 & ~st.s3;
    assign fall_o  = ~st.s2 & st.s3;

endmodule // bzcs_sync_edge

//--- verif/bzcs_mcu_model.sv
`timescale 1ns/1ps

// controller side: gate-drive pwm pins and the step pulse pin
module bzcs_mcu_model (
    input  wire logic       ref_clk_i, // core clock, pacing only
    output logic      [2:0] hs_o,      // high-side pwm pins
    output logic      [2:0] ls_o,      // low-side pwm pins
    output logic            step_o     // step pulse pin
);
    // all switches off at power-up
    initial begin
        hs_o = 3'h0;
        ls_o = 3'h0;
        step_o = 1'h0;
    end

    // one pin change just after an edge; passive freewheel uses polarity 0
    // comparator choice per duty is left to the caller
    task automatic set_pin(input bit low, input int idx, input logic v);
        @(posedge ref_clk_i);
        if (low)
            ls_o[idx] <= v;
        else
            hs_o[idx] <= v;
    endtask

    // pulse kept well over 40 cycles, since the device does not check width
    task automatic step_pulse();
        @(posedge ref_clk_i);
        step_o <= 1'h1;
        repeat (48) @(posedge ref_clk_i);
        step_o <= 1'h0;
        repeat (48) @(posedge ref_clk_i);
    endtask
endmodule // bzcs_mcu_model

//--- verif/tb_bzcs_zero_cross_sampler.sv
`timescale 1ns/1ps

module tb_bzcs_zero_cross_sampler;
    import bzcs_pkg::*;
    logic              ref_clk_i    = 1'h0;
    logic              rst_i        = 1'h1;
    logic [ADDR_W-1:0] addr_i       = 4'h0;
    logic [DATA_W-1:0] wr_data_i    = 8'h00;
    logic              wr_i         = 1'h0;
    logic              rd_i         = 1'h0;
    logic [2:0]        cmps         = 3'h0;
    logic [DATA_W-1:0] rd_data_o;
    logic [2:0]        hs;
    logic [2:0]        ls;
    logic              step_pin;
    logic [2:0]        phase_route_o;
    logic              zero_cross_out_o;
    logic              zc_exp       = 1'h0;
    logic [DATA_W-1:0] d;
    int                n_mismatch   = 0;
    int                total_checks = 0;
    int                cycles       = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    bzcs_mcu_model host (.ref_clk_i(ref_clk_i), .hs_o(hs), .ls_o(ls), .step_o(step_pin));

    bzcs_zero_cross_sampler dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .high_side_drive_in_i(hs),
        .low_side_drive_in_i(ls), .step_pulse_in_i(step_pin), .cmp_gnd_i(cmps[0]),
        .cmp_supply_i(cmps[1]), .cmp_half_i(cmps[2]), .phase_route_o(phase_route_o),
        .zero_cross_out_o(zero_cross_out_o));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, the whole run needs about a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("BAD %0t timeout", $time);
            close_out();
        end
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // strobes drop one edge later, so back-to-back calls never clash
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'h1;
        @(posedge ref_clk_i);
        wr_i <= 1'h0;
    endtask

    // data stands only in the cycle after the strobe; looked at mid-cycle, away from edges
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge ref_clk_i);
        rd_i <= 1'h0;
        @(negedge ref_clk_i);
        v = rd_data_o;
        @(negedge ref_clk_i);
        chk_reg(rd_data_o, 8'h00, "read data lingers");
    endtask

    // floating phase expected for step s: 1,4 ph3; 2,5 ph2; 3,6 ph1
    task automatic chk_step(input int s);
        logic [2:0] r;
        r = (s % 3 == 1) ? 3'h4 : (s % 3 == 2) ? 3'h2 : 3'h1;
        rd(ADDR_STATUS, d);
        chk_pin(d[6:4], r, "status route");
        chk_pin(phase_route_o, r, "route pin");
    endtask

    // wrong edge and a non-driving phase must not sample, the right edge must
    task automatic samp(input logic [2:0] cfg, input bit low, input int ph, input bit rise,
                        input int which);
        logic       v;
        logic [2:0] c;
        v = ~zc_exp;
        c = {3{~v}};
        c[which] = v;
        wr(ADDR_CTRL, {5'h00, cfg});
        cmps <= {3{zc_exp}};
        host.set_pin(low, ph, rise);
        repeat (8) @(posedge ref_clk_i);
        cmps <= c;
        host.set_pin(low, (ph + 1) % 3, rise);
        host.set_pin(low, (ph + 1) % 3, ~rise);
        host.set_pin(low, ph, ~rise);
        repeat (8) @(posedge ref_clk_i);
        chk_pin({2'h0, zero_cross_out_o}, {2'h0, zc_exp}, "sampled off edge");
        host.set_pin(low, ph, rise);
        repeat (8) @(posedge ref_clk_i);
        chk_pin({2'h0, zero_cross_out_o}, {2'h0, v}, "missed sample edge");
        rd(ADDR_STATUS, d);
        chk_reg({7'h00, d[1]}, {7'h00, v}, "selected comparator");
        chk_reg({7'h00, d[0]}, {7'h00, v}, "status zero cross");
        zc_exp = v;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        rd(ADDR_CTRL, d);
        chk_reg(d, CTRL_RESET, "ctrl reset");
        rd(4'hc, d);
        chk_reg(d, 8'h00, "unmapped read");
        chk_step(1);
        $display("reset test done");
        for (int s = 1; s <= 6; s++) begin
            wr(ADDR_STEP, s[7:0]);
            chk_step(s);
        end
        wr(ADDR_STEP, 8'h00);
        wr(ADDR_STEP, 8'h07);
        chk_step(6);
        host.step_pulse();
        chk_step(6);
        $display("serial step test done");
        wr(ADDR_CTRL, 8'h10);
        host.step_pulse();
        chk_step(1);
        wr(ADDR_STEP, 8'h04);
        chk_step(1);
        host.step_pulse();
        chk_step(2);
        wr(ADDR_CTRL, 8'h30);
        host.step_pulse();
        chk_step(1);
        host.step_pulse();
        chk_step(6);
        $display("pulse step test done");
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_STEP, 8'h01);
        samp(3'h0, 0, 0, 1, 0);
        samp(3'h4, 1, 0, 0, 0);
        samp(3'h2, 1, 0, 1, 1);
        samp(3'h6, 0, 0, 0, 1);
        samp(3'h1, 0, 0, 0, 2);
        samp(3'h5, 0, 0, 0, 2);
        samp(3'h3, 1, 0, 0, 2);
        samp(3'h7, 1, 0, 0, 2);
        wr(ADDR_STEP, 8'h03);
        samp(3'h1, 0, 1, 0, 2);
        wr(ADDR_STEP, 8'h06);
        samp(3'h0, 0, 2, 1, 0);
        $display("edge table test done");
        // full duty: driving pin held on, so only the internal rate samples
        host.set_pin(0, 2, 1'h1);
        wr(ADDR_CTRL, 8'h09);
        cmps <= {3{~zc_exp}};
        repeat (8) @(posedge ref_clk_i);
        chk_pin({2'h0, zero_cross_out_o}, {2'h0, ~zc_exp}, "bypass sample");
        $display("bypass test done");
        // mid-run reset puts the counter, route and output back to reset values
        rst_i <= 1'h1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        rd(ADDR_STEP, d);
        chk_reg(d, {5'h00, STEP_RESET}, "step after reset");
        chk_pin({2'h0, zero_cross_out_o}, 3'h0, "zero cross after reset");
        chk_step(1);
        $display("mid-run reset test done");
        close_out();
    end
endmodule // tb_bzcs_zero_cross_sampler
